/* File: pkg/plpc_pkg.sv */
`default_nettype none
package plpc_pkg;

  // ==========================================================================
  // Widths and line size
  // ==========================================================================
  localparam int WORD_W    = 16;
  localparam int CHAR_W    = 7;
  localparam int LINE_COLS = 132;
  localparam int COL_W     = 8;

  // ==========================================================================
  // Output command word fields (word bit 0 is the most significant bit)
  // ==========================================================================
  localparam int CMD_XFER_POS = 15;
  localparam int CMD_DCON_POS = 13;
  localparam int CMD_SCON_POS = 12;
  localparam int CMD_EOB_POS  = 11;
  localparam int CMD_TERM_POS = 10;
  localparam int CMD_FMT_POS  = 9;
  localparam int MOT_HI       = 6;
  localparam int MOT_LO       = 0;
  localparam logic [6:0] MOT_CODE_LINE = 7'h0A;
  localparam logic [6:0] MOT_CODE_TOF  = 7'h0C;

  // ==========================================================================
  // Instruction word device address fields
  // ==========================================================================
  localparam int ADR_GRP_HI  = 9;
  localparam int ADR_GRP_LO  = 8;
  localparam int ADR_UNIT_HI = 3;
  localparam int ADR_UNIT_LO = 0;

  // ==========================================================================
  // Status word bit positions
  // ==========================================================================
  localparam int ST_OK_POS   = 15;
  localparam int ST_INOP_POS = 12;
  localparam int ST_BUSY_POS = 8;
  localparam int ST_NRDY_POS = 7;
  localparam int ST_PLOW_POS = 6;
  localparam int ST_BOF_POS  = 5;
  localparam int ST_HOLD_POS = 3;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    PLPC_FN_NONE   = 2'b00,
    PLPC_FN_CMD    = 2'b01,
    PLPC_FN_DATA   = 2'b10,
    PLPC_FN_STATUS = 2'b11
  } plpc_func_e;

  typedef enum logic [1:0] {
    PLPC_MOT_NONE = 2'b00,
    PLPC_MOT_LINE = 2'b01,
    PLPC_MOT_TOF  = 2'b10
  } plpc_motion_e;

  typedef enum logic [2:0] {
    PLPC_ST_IDLE  = 3'b000,
    PLPC_ST_XFER  = 3'b001,
    PLPC_ST_PRINT = 3'b010,
    PLPC_ST_FEED  = 3'b011,
    PLPC_ST_ADV   = 3'b100
  } plpc_state_e;

  typedef struct packed {
    logic                valid;
    plpc_func_e          func;
    logic [WORD_W-1:0]   word;
    logic [WORD_W-1:0]   data;
  } plpc_io_req_s;

  typedef struct packed {
    logic power_ok;
    logic selected;
    logic paper_low;
    logic bottom_of_form;
    logic fault;
  } plpc_sense_s;

endpackage
`default_nettype wire

/* File: src/plpc_irq_chan.sv */
`timescale 1ns/100ps
`default_nettype none
module plpc_irq_chan (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic conn_load,
  input  wire logic conn_val,
  input  wire logic set_evt,
  input  wire logic ack,
  output logic      irq
);
  logic connected_reg;
  logic pending_reg;
  logic conn_now;

  // ==========================================================================
  // Connection and pending flag
  // ==========================================================================
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      connected_reg <= 1'b0;
    end else if (conn_load) begin
      connected_reg <= conn_val;
    end
  end

  // A command that connects the channel also lets its own event through.
  assign conn_now = conn_load ? conn_val : connected_reg;

  // Disconnect drops the pending flag; otherwise a new event beats an ack.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pending_reg <= 1'b0;
    end else if (conn_load && !conn_val) begin
      pending_reg <= 1'b0;
    end else if (set_evt && conn_now) begin
      pending_reg <= 1'b1;
    end else if (ack) begin
      pending_reg <= 1'b0;
    end
  end

  assign irq = pending_reg;

  AST_SET_WINS: assert property (
    @(posedge mclk) disable iff (sys_rst)
    set_evt && conn_now |=> irq)
    else $error("Connected event did not raise the interrupt.");
endmodule
`default_nettype wire

/* File: src/plpc_line_buf.sv */
`timescale 1ns/100ps
`default_nettype none
module plpc_line_buf #(
  parameter int COLS  = plpc_pkg::LINE_COLS,
  parameter int CW    = plpc_pkg::CHAR_W,
  parameter int AW    = plpc_pkg::COL_W
) (
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  input  wire logic          clr,
  input  wire logic          wr_en,
  input  wire logic [CW-1:0] wr_char,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [CW-1:0] rd_char,
  output logic      [AW-1:0] count,
  output logic               full
);
  logic [CW-1:0] mem [COLS];
  logic [AW-1:0] count_reg;

  // ==========================================================================
  // Column store
  // ==========================================================================
  always_ff @(posedge mclk) begin
    if (wr_en && !full) begin
      mem[count_reg] <= wr_char;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || clr) begin
      count_reg <= '0;
    end else if (wr_en && !full) begin
      count_reg <= count_reg + AW'(1);
    end
  end

  // Columns past the stored line read as zero.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_char <= '0;
    end else if (rd_addr < count_reg) begin
      rd_char <= mem[rd_addr];
    end else begin
      rd_char <= '0;
    end
  end

  assign count = count_reg;
  assign full  = (count_reg == AW'(COLS));
endmodule
`default_nettype wire

/* File: src/plpc_ctrl.sv */
// How it works
// - Characters arrive only through host instructions.
// - Transfer runs until terminate or 132 columns.
// - Transfer end prints, feeds, then raises service.
// - Command bit 2 connects or clears data interrupt.
// - Command bit 3 connects or clears service interrupt.
// - Control format moves paper without printing.
// - Bits 9-15 pick line feed or top form.
// - Finished paper advance raises connected service interrupt.
// - Data out stores one 7-bit ASCII character.
// - Respond only when group and unit match.
// - Bit 3 inoperable; bit 0 its inverse.
// - Bit 7 shows busy with transfer, print or advance.
// - Bit 8 low means buffer ready for data.
// - Bits 9, 10 paper low, bottom form.
// - Bit 12 hold; commands wait for select.
// - Buffer empty and end-of-block raise data interrupt.
// - Command end or malfunction while busy raises service interrupt.
// - Terminate while idle raises service interrupt at once.
`timescale 1ns/100ps
`default_nettype none
module plpc_ctrl #(
  parameter logic [1:0] DEV_GROUP = 2'h0,
  parameter logic [3:0] DEV_UNIT  = 4'h7
) (
  input  wire logic                           mclk,
  input  wire logic                           sys_rst,
  input  wire plpc_pkg::plpc_io_req_s         io_req,
  input  wire logic                           data_irq_ack,
  input  wire logic                           service_irq_ack,
  input  wire plpc_pkg::plpc_sense_s          sense,
  input  wire logic                           prn_done,
  input  wire logic [plpc_pkg::COL_W-1:0]     prn_col_addr,
  output logic                                data_irq,
  output logic                                service_irq,
  output logic [plpc_pkg::WORD_W-1:0]         status_word,
  output logic                                status_valid,
  output logic                                prn_print_req,
  output logic                                prn_move_req,
  output plpc_pkg::plpc_motion_e              prn_motion,
  output logic [plpc_pkg::CHAR_W-1:0]         prn_col_char,
  output logic [plpc_pkg::COL_W-1:0]          prn_line_len
);
  import plpc_pkg::*;

  plpc_state_e         state_reg;
  logic [WORD_W-1:0]   held_cmd_reg;
  logic                held_valid_reg;
  logic [CHAR_W-1:0]   char_reg;
  logic                char_full_reg;
  logic                addr_ok;
  logic                cmd_take;
  logic                data_take;
  logic                stat_take;
  logic                exec_now;
  logic [WORD_W-1:0]   exec_cmd;
  logic                is_xfer;
  logic                is_eob;
  logic                is_term;
  logic                is_fmt;
  logic                is_noop;
  logic [6:0]          mot_code;
  logic                mot_known;
  plpc_motion_e        mot_sel;
  logic                inop;
  logic                trouble;
  logic                busy;
  logic                buf_full;
  logic                buf_ready;
  logic                buf_clr;
  logic                data_set;
  logic                svc_set;
  logic                motion_end;

  // ==========================================================================
  // Instruction decode
  // ==========================================================================
  assign addr_ok = (io_req.word[ADR_GRP_HI:ADR_GRP_LO] == DEV_GROUP) &&
                   (io_req.word[ADR_UNIT_HI:ADR_UNIT_LO] == DEV_UNIT);
  assign cmd_take  = io_req.valid && addr_ok && (io_req.func == PLPC_FN_CMD);
  assign data_take = io_req.valid && addr_ok &&
                     (io_req.func == PLPC_FN_DATA);
  assign stat_take = io_req.valid && addr_ok &&
                     (io_req.func == PLPC_FN_STATUS);

  assign inop    = !sense.power_ok;
  assign trouble = inop || sense.fault;
  assign busy    = (state_reg != PLPC_ST_IDLE);

  // A command taken while in hold waits here until the printer is selected.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      held_valid_reg <= 1'b0;
      held_cmd_reg   <= '0;
    end else if (cmd_take && (!sense.selected || held_valid_reg)) begin
      held_valid_reg <= 1'b1;
      held_cmd_reg   <= io_req.data;
    end else if (held_valid_reg && sense.selected) begin
      held_valid_reg <= 1'b0;
    end
  end

  always_comb begin
    exec_now = 1'b0;
    exec_cmd = io_req.data;
    if (held_valid_reg && sense.selected) begin
      exec_now = 1'b1;
      exec_cmd = held_cmd_reg;
    end else if (cmd_take && sense.selected) begin
      exec_now = 1'b1;
    end
  end

  assign is_xfer = exec_cmd[CMD_XFER_POS];
  assign is_eob  = !is_xfer && exec_cmd[CMD_EOB_POS];
  assign is_term = !is_xfer && exec_cmd[CMD_TERM_POS];
  assign is_fmt  = !is_xfer && !is_eob && !is_term && exec_cmd[CMD_FMT_POS];
  assign is_noop = !is_xfer && !is_eob && !is_term && !is_fmt;
  assign mot_code = exec_cmd[MOT_HI:MOT_LO];

  always_comb begin
    mot_known = 1'b1;
    mot_sel   = PLPC_MOT_NONE;
    if (mot_code == MOT_CODE_LINE) begin
      mot_sel = PLPC_MOT_LINE;
    end else if (mot_code == MOT_CODE_TOF) begin
      mot_sel = PLPC_MOT_TOF;
    end else begin
      mot_known = 1'b0;
    end
  end

  // ==========================================================================
  // Character holding register
  // ==========================================================================
  assign buf_ready = (state_reg == PLPC_ST_XFER) && !char_full_reg &&
                     !buf_full;

  // A character sent while the buffer is not ready is dropped.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      char_full_reg <= 1'b0;
      char_reg      <= '0;
    end else if (data_take && buf_ready) begin
      char_full_reg <= 1'b1;
      char_reg      <= io_req.data[CHAR_W-1:0];
    end else begin
      char_full_reg <= 1'b0;
    end
  end

  assign buf_clr = (state_reg == PLPC_ST_IDLE) && exec_now && is_xfer;

  plpc_line_buf u_line_buf (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .clr     (buf_clr),
    .wr_en   (char_full_reg),
    .wr_char (char_reg),
    .rd_addr (prn_col_addr),
    .rd_char (prn_col_char),
    .count   (prn_line_len),
    .full    (buf_full)
  );

  // ==========================================================================
  // Command sequencer
  // ==========================================================================
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg     <= PLPC_ST_IDLE;
      prn_print_req <= 1'b0;
      prn_move_req  <= 1'b0;
      prn_motion    <= PLPC_MOT_NONE;
    end else begin
      prn_print_req <= 1'b0;
      prn_move_req  <= 1'b0;
      case (state_reg)
        PLPC_ST_IDLE: begin
          if (exec_now && is_xfer && !trouble) begin
            state_reg <= PLPC_ST_XFER;
          end else if (exec_now && is_fmt && mot_known && !trouble) begin
            state_reg    <= PLPC_ST_ADV;
            prn_move_req <= 1'b1;
            prn_motion   <= mot_sel;
          end
        end
        PLPC_ST_XFER: begin
          if (trouble) begin
            state_reg <= PLPC_ST_IDLE;
          end else if ((exec_now && is_term) || buf_full) begin
            state_reg     <= PLPC_ST_PRINT;
            prn_print_req <= 1'b1;
          end
        end
        PLPC_ST_PRINT: begin
          if (trouble) begin
            state_reg <= PLPC_ST_IDLE;
          end else if (prn_done) begin
            state_reg    <= PLPC_ST_FEED;
            prn_move_req <= 1'b1;
            prn_motion   <= PLPC_MOT_LINE;
          end
        end
        PLPC_ST_FEED, PLPC_ST_ADV: begin
          if (trouble || prn_done) begin
            state_reg <= PLPC_ST_IDLE;
          end
        end
        default: begin
          state_reg <= PLPC_ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Interrupt events
  // ==========================================================================
  assign motion_end = ((state_reg == PLPC_ST_FEED) ||
                       (state_reg == PLPC_ST_ADV)) && prn_done && !trouble;
  assign data_set = buf_clr || char_full_reg ||
                    (exec_now && is_eob);
  assign svc_set  = motion_end || (busy && trouble) ||
                    (exec_now && is_term && !busy);

  plpc_irq_chan u_data_irq (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .conn_load (exec_now),
    .conn_val  (exec_cmd[CMD_DCON_POS]),
    .set_evt   (data_set),
    .ack       (data_irq_ack),
    .irq       (data_irq)
  );

  plpc_irq_chan u_svc_irq (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .conn_load (exec_now),
    .conn_val  (exec_cmd[CMD_SCON_POS]),
    .set_evt   (svc_set),
    .ack       (service_irq_ack),
    .irq       (service_irq)
  );

  // ==========================================================================
  // Status word
  // ==========================================================================
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      status_word  <= '0;
      status_valid <= 1'b0;
    end else begin
      status_valid <= stat_take;
      if (stat_take) begin
        status_word              <= '0;
        status_word[ST_OK_POS]   <= !inop;
        status_word[ST_INOP_POS] <= inop;
        status_word[ST_BUSY_POS] <= busy;
        status_word[ST_NRDY_POS] <= !buf_ready;
        status_word[ST_PLOW_POS] <= sense.paper_low;
        status_word[ST_BOF_POS]  <= sense.bottom_of_form;
        status_word[ST_HOLD_POS] <= sense.power_ok &&
                                    !sense.selected;
      end
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence s_print_done;
    (state_reg == PLPC_ST_PRINT) && prn_done && !trouble;
  endsequence

  sequence s_feed_started;
    (state_reg == PLPC_ST_FEED) && prn_move_req &&
    (prn_motion == PLPC_MOT_LINE) && !prn_print_req;
  endsequence

  AST_PRINT_THEN_FEED: assert property (
    s_print_done |=> s_feed_started)
    else $error("Print completion did not start one line feed.");

  AST_FULL_LINE_PRINTS: assert property (
    (state_reg == PLPC_ST_XFER) && buf_full && !trouble
    |=> (state_reg == PLPC_ST_PRINT) && prn_print_req)
    else $error("Full line did not start printing.");

  AST_FORMAT_NO_PRINT: assert property (
    (state_reg == PLPC_ST_IDLE) && exec_now && is_fmt &&
    (mot_code == MOT_CODE_TOF) && !trouble
    |=> (state_reg == PLPC_ST_ADV) && (prn_motion == PLPC_MOT_TOF) &&
        !prn_print_req)
    else $error("Top of form advance not started correctly.");

  AST_DATA_DISCONNECT: assert property (
    exec_now && !exec_cmd[CMD_DCON_POS] |=> !data_irq)
    else $error("Data interrupt survived disconnect.");

  AST_SVC_DISCONNECT: assert property (
    exec_now && !exec_cmd[CMD_SCON_POS] |=> !service_irq)
    else $error("Service interrupt survived disconnect.");

  AST_TERM_IDLE_SI: assert property (
    (state_reg == PLPC_ST_IDLE) && exec_now && is_term &&
    exec_cmd[CMD_SCON_POS] |=> service_irq)
    else $error("Terminate while idle gave no service interrupt.");

  AST_OK_BIT: assert property (
    status_valid |-> status_word[ST_OK_POS] != status_word[ST_INOP_POS])
    else $error("Status ok bit does not mirror inoperable bit.");

  AST_BUSY_BIT: assert property (
    stat_take |=> status_valid &&
    (status_word[ST_BUSY_POS] == $past(busy)))
    else $error("Status busy bit wrong.");

  AST_HOLD_STORES: assert property (
    cmd_take && !sense.selected |=> held_valid_reg)
    else $error("Command in hold was not stored.");

  AST_NOOP_STAYS: assert property (
    (state_reg == PLPC_ST_IDLE) && exec_now && is_noop
    |=> (state_reg == PLPC_ST_IDLE) && !prn_move_req)
    else $error("No-op started printer activity.");
endmodule
`default_nettype wire

/* File: sim/plpc_printer_model.sv */
`timescale 1ns/100ps
`default_nettype none
module plpc_printer_model (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       print_req,
  input  wire logic       move_req,
  input  wire logic [6:0] col_char,
  input  wire logic [7:0] line_len,
  input  wire logic [7:0] busy_len,
  output logic            done,
  output logic      [7:0] col_addr
);
  logic [6:0] line_seen [0:131];

  // ==========================================================================
  // Mechanism
  // ==========================================================================
  // A print reads the stored line back first; every request then ends with
  // one done pulse after busy_len cycles, so the bench sets the pace.
  initial begin
    done = 1'b0;
    col_addr = 8'hFF;
    forever begin
      @(negedge mclk);
      done = 1'b0;
      if (!sys_rst && (print_req || move_req)) begin
        if (print_req) begin
          for (int i = 0; i < line_len; i++) begin
            col_addr = i[7:0];
            @(negedge mclk);
            @(negedge mclk);
            line_seen[i] = col_char;
          end
          col_addr = 8'hFF;
        end
        repeat (busy_len) @(negedge mclk);
        done = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/parallel_line_printer_controller_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module parallel_line_printer_controller_bench;
  import plpc_pkg::*;
  logic mclk, sys_rst, data_irq_ack, service_irq_ack, prn_done;
  logic data_irq, service_irq, status_valid, prn_print_req, prn_move_req;
  plpc_io_req_s io_req;
  plpc_sense_s  sense;
  plpc_motion_e prn_motion;
  logic [15:0]  status_word;
  logic [7:0]   prn_col_addr, prn_line_len, busy_len;
  logic [6:0]   prn_col_char;
  int           err_total, compares;

  plpc_ctrl #(.DEV_GROUP(2'h0), .DEV_UNIT(4'h7)) u_dut (
    .mclk(mclk), .sys_rst(sys_rst), .io_req(io_req),
    .data_irq_ack(data_irq_ack), .service_irq_ack(service_irq_ack),
    .sense(sense), .prn_done(prn_done), .prn_col_addr(prn_col_addr),
    .data_irq(data_irq), .service_irq(service_irq),
    .status_word(status_word), .status_valid(status_valid),
    .prn_print_req(prn_print_req), .prn_move_req(prn_move_req),
    .prn_motion(prn_motion), .prn_col_char(prn_col_char),
    .prn_line_len(prn_line_len));

  plpc_printer_model u_prn (
    .mclk(mclk), .sys_rst(sys_rst), .print_req(prn_print_req),
    .move_req(prn_move_req), .col_char(prn_col_char),
    .line_len(prn_line_len), .busy_len(busy_len), .done(prn_done),
    .col_addr(prn_col_addr));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic give_verdict();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic issue(input plpc_func_e fn, input logic [15:0] dat,
                       input logic [15:0] wrd = 16'h0007);
    @(negedge mclk);
    io_req = '{valid: 1'b1, func: fn, word: wrd, data: dat};
    @(negedge mclk);
    io_req.valid = 1'b0;
  endtask

  task automatic ack(input logic svc);
    @(negedge mclk);
    if (svc) service_irq_ack = 1'b1;
    else data_irq_ack = 1'b1;
    @(negedge mclk);
    service_irq_ack = 1'b0;
    data_irq_ack = 1'b0;
  endtask

  // Sources: 0 data irq, 1 service irq, 2 move, 3 print, 4 status valid.
  task automatic wait_for(input int which, input int lim, output logic hit);
    logic s;
    hit = 1'b0;
    for (int n = 0; n < lim && !hit; n++) begin
      case (which)
        0: s = data_irq;
        1: s = service_irq;
        2: s = prn_move_req;
        3: s = prn_print_req;
        default: s = status_valid;
      endcase
      if (s === 1'b1) hit = 1'b1;
      else @(negedge mclk);
    end
  endtask

  task automatic expect_ev(input int which, input int lim);
    logic hit;
    wait_for(which, lim, hit);
    chk_bit(hit, 1'b1);
    if (!hit) give_verdict();
  endtask

  task automatic read_status(output logic [15:0] st);
    issue(PLPC_FN_STATUS, 16'h0000);
    expect_ev(4, 4);
    st = status_word;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_status();
    logic [3:0]  cfg [0:4] = '{4'hC, 4'hE, 4'hD, 4'h4, 4'h8};
    logic [15:0] exp [0:4] = '{16'h8000, 16'h8040, 16'h8020, 16'h1000,
                               16'h8008};
    logic [15:0] st;
    logic        hit;
    chk_bit(service_irq, 1'b0);
    for (int i = 0; i < 5; i++) begin
      {sense.power_ok, sense.selected, sense.paper_low,
       sense.bottom_of_form} = cfg[i];
      read_status(st);
      chk_word(st & 16'hFF7F, exp[i]);
    end
    sense = '{power_ok: 1'b1, selected: 1'b1, default: 1'b0};
    issue(PLPC_FN_STATUS, 16'h0000, 16'h0006);
    issue(PLPC_FN_STATUS, 16'h0000, 16'h0107);
    wait_for(4, 4, hit);
    chk_bit(hit, 1'b0);
  endtask

  task automatic t_line();
    logic [6:0]  chars [0:2] = '{7'h41, 7'h30, 7'h5A};
    logic [15:0] st;
    issue(PLPC_FN_CMD, 16'hB000);
    expect_ev(0, 4);
    read_status(st);
    chk_word(st, 16'h8100);
    for (int i = 0; i < 3; i++) begin
      ack(1'b0);
      chk_bit(data_irq, 1'b0);
      issue(PLPC_FN_DATA, {9'h000, chars[i]});
      expect_ev(0, 6);
      st = 16'hFFFF;
      for (int n = 0; n < 8 && st[7] !== 1'b0; n++) read_status(st);
      chk_bit(st[7], 1'b0);
      repeat (2000) @(negedge mclk);
    end
    issue(PLPC_FN_CMD, 16'h3400);
    expect_ev(3, 6);
    chk_word(16'(prn_line_len), 16'h0003);
    expect_ev(2, 40);
    chk_word(16'(prn_motion), 16'h0001);
    expect_ev(1, 40);
    for (int i = 0; i < 3; i++)
      chk_word(16'(u_prn.line_seen[i]), 16'(chars[i]));
  endtask

  task automatic t_disconnect();
    logic hit;
    issue(PLPC_FN_CMD, 16'h0000);
    repeat (2) @(negedge mclk);
    chk_bit(data_irq, 1'b0);
    chk_bit(service_irq, 1'b0);
    wait_for(2, 10, hit);
    chk_bit(hit, 1'b0);
  endtask

  task automatic t_full();
    issue(PLPC_FN_CMD, 16'h8000);
    for (int i = 0; i < 132; i++)
      issue(PLPC_FN_DATA, 16'h0020 + 16'(i % 64));
    expect_ev(3, 6);
    chk_word(16'(prn_line_len), 16'h0084);
    expect_ev(2, 400);
    repeat (20) @(negedge mclk);
    chk_bit(service_irq, 1'b0);
    for (int i = 0; i < 132; i++)
      chk_word(16'(u_prn.line_seen[i]), 16'h0020 + 16'(i % 64));
  endtask

  task automatic t_format();
    logic [15:0] codes [0:1] = '{16'h000A, 16'h000C};
    logic hit;
    for (int i = 0; i < 2; i++) begin
      issue(PLPC_FN_CMD, 16'h5200 | codes[i]);
      expect_ev(2, 4);
      chk_word(16'(prn_motion), 16'(i + 1));
      expect_ev(1, 40);
      ack(1'b1);
      chk_bit(service_irq, 1'b0);
    end
    issue(PLPC_FN_CMD, 16'h5201);
    wait_for(2, 10, hit);
    chk_bit(hit, 1'b0);
  endtask

  task automatic t_term_eob();
    issue(PLPC_FN_CMD, 16'h1400);
    expect_ev(1, 3);
    ack(1'b1);
    issue(PLPC_FN_CMD, 16'h2800);
    expect_ev(0, 3);
    ack(1'b0);
  endtask

  task automatic t_hold();
    logic hit;
    sense.selected = 1'b0;
    issue(PLPC_FN_CMD, 16'h520A);
    wait_for(2, 20, hit);
    chk_bit(hit, 1'b0);
    sense.selected = 1'b1;
    expect_ev(2, 4);
    expect_ev(1, 40);
    ack(1'b1);
  endtask

  task automatic t_fault();
    logic [15:0] st;
    busy_len = 8'd100;
    issue(PLPC_FN_CMD, 16'h520C);
    expect_ev(2, 4);
    @(negedge mclk);
    sense.fault = 1'b1;
    expect_ev(1, 4);
    read_status(st);
    chk_bit(st[8], 1'b0);
    sense.fault = 1'b0;
    repeat (120) @(negedge mclk);
    busy_len = 8'd3;
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial begin
    err_total = 0;
    compares = 0;
    sys_rst = 1'b1;
    io_req = '0;
    data_irq_ack = 1'b0;
    service_irq_ack = 1'b0;
    busy_len = 8'd3;
    sense = '{power_ok: 1'b1, selected: 1'b1, default: 1'b0};
    repeat (8) @(negedge mclk);
    sys_rst = 1'b0;
    t_status();
    t_line();
    t_disconnect();
    t_full();
    t_format();
    t_term_eob();
    t_hold();
    t_fault();
    give_verdict();
  end
endmodule
`default_nettype wire
